// [design/iak_core_end.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// processor core end: takes requests, stacks, vectors, returns
module iak_core_end
  import iak_pkg::*;
(
  input  wire logic        clk,              // system clock
  input  wire logic        nrst,             // async reset, active low
  iak_link_if.core         link,             // arbiter side
  input  wire logic [2:0]  avsAddress,       // avalon word index
  input  wire logic        avsRead,          // avalon read
  input  wire logic        avsWrite,         // avalon write
  input  wire logic [31:0] avsWritedata,     // avalon write data
  output logic [31:0]      avsReaddata,      // avalon read data
  output logic             avsWaitrequest,   // avalon waitrequest
  output logic             stackWe,          // stack word write pulse
  output logic [15:0]      stackAddr,        // stack word address
  output logic [15:0]      stackData,        // stack word data
  output logic             vecRd,            // vector table read pulse
  output logic [15:0]      vecAddr,          // vector table address
  input  wire logic [15:0] vecData           // table entry, cycle after vecRd
);
  import iak_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [2:0] {IDLE, PUSH_PC, PUSH_CCR, FETCH, TBL_WAIT, LOAD} iak_seq_type;

  typedef struct packed {
    iak_seq_type seq;         // sequence state
    logic [15:0] pc;          // program counter
    logic [7:0]  condition_code_reg;         // condition_code_reg
    logic [15:0] sp;          // stack pointer
    logic [15:0] stkPc;       // last stacked counter
    logic [15:0] stkCcrW;     // last stacked condition word
    logic [5:0]  lastVec;     // latched vector
    logic [15:0] devAddr;     // device register address
    logic        devBusy;     // device read in flight
    logic        wait_;       // waitrequest
    logic [31:0] rdata;       // avalon read data
    logic        regWr;       // link write pulse
    logic        regRd;       // link read pulse
    logic [7:0]  regWdata;    // link write data
    logic        irqAck;      // link ack pulse
    logic        stackWe;     // stack write pulse
    logic [15:0] stackAddr;   // stack address
    logic [15:0] stackData;   // stack data
    logic        vecRd;       // table read pulse
    logic [15:0] vecAddr;     // table address
  } iak_core_state_type;

  iak_core_state_type cur_ff;  // registered state
  iak_core_state_type nxt_ff;  // next state

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic [31:0] rdMux;       // plain register read value
    rdMux  = '0;
    nxt_ff = cur_ff;
    nxt_ff.regWr   = 1'b0;
    nxt_ff.regRd   = 1'b0;
    nxt_ff.irqAck  = 1'b0;
    nxt_ff.stackWe = 1'b0;
    nxt_ff.vecRd   = 1'b0;

    case (avsAddress)
      AV_CMD:      rdMux = {30'h0, cur_ff.seq != IDLE, cur_ff.condition_code_reg[MASK_FLAG_BIT]};
      AV_PC:       rdMux = {16'h0, cur_ff.pc};
      AV_CCR:      rdMux = {24'h0, cur_ff.condition_code_reg};
      AV_SP:       rdMux = {16'h0, cur_ff.sp};
      AV_DEV_ADDR: rdMux = {16'h0, cur_ff.devAddr};
      AV_LAST_VEC: rdMux = {26'h0, cur_ff.lastVec};
      default:     rdMux = 32'h0;  // unmapped reads zero
    endcase

    // avalon: waitrequest drops one cycle, the access completes there
    if (!cur_ff.wait_)
    begin
      nxt_ff.wait_ = 1'b1;
      if (avsWrite)
      begin
        case (avsAddress)
          AV_CMD:
          begin
            if (avsWritedata[CMD_RETURN] && cur_ff.seq == IDLE)
            begin
              nxt_ff.condition_code_reg = cur_ff.stkCcrW[15:8];
              nxt_ff.pc  = cur_ff.stkPc;
              nxt_ff.sp  = cur_ff.sp + 16'h0004;
            end
            else if (avsWritedata[CMD_INSTR_END] && !avsWritedata[CMD_CCR_MOD] &&
                     cur_ff.seq == IDLE && link.irqReq)
            begin
              nxt_ff.seq     = PUSH_PC;
              nxt_ff.lastVec = link.irqVector;
              nxt_ff.irqAck  = 1'b1;
            end
          end
          AV_PC:       nxt_ff.pc      = avsWritedata[15:0];
          AV_CCR:      nxt_ff.condition_code_reg     = avsWritedata[7:0];
          AV_SP:       nxt_ff.sp      = avsWritedata[15:0];
          AV_DEV_ADDR: nxt_ff.devAddr = avsWritedata[15:0];
          AV_DEV_DATA:
          begin
            nxt_ff.regWr    = 1'b1;
            nxt_ff.regWdata = avsWritedata[7:0];
          end
          default:     ;  // unmapped write ignored
        endcase
      end
    end
    else if (avsRead && avsAddress == AV_DEV_DATA)
    begin
      // device read goes over the link and waits for its answer
      if (!cur_ff.devBusy)
      begin
        nxt_ff.devBusy = 1'b1;
        nxt_ff.regRd   = 1'b1;
      end
      else if (link.regRdValid)
      begin
        nxt_ff.devBusy = 1'b0;
        nxt_ff.rdata   = {24'h0, link.regRdata};
        nxt_ff.wait_   = 1'b0;
      end
    end
    else if (avsRead || avsWrite)
    begin
      nxt_ff.rdata = rdMux;
      nxt_ff.wait_ = 1'b0;
    end

    // interrupt sequence
    case (cur_ff.seq)
      IDLE:     ;
      PUSH_PC:
      begin
        nxt_ff.stackWe   = 1'b1;
        nxt_ff.stackAddr = cur_ff.sp - 16'h0002;
        nxt_ff.stackData = cur_ff.pc;
        nxt_ff.stkPc     = cur_ff.pc;
        nxt_ff.sp        = cur_ff.sp - 16'h0002;
        nxt_ff.seq       = PUSH_CCR;
      end
      PUSH_CCR:
      begin
        nxt_ff.stackWe   = 1'b1;
        nxt_ff.stackAddr = cur_ff.sp - 16'h0002;
        nxt_ff.stackData = {cur_ff.condition_code_reg, cur_ff.condition_code_reg};
        nxt_ff.stkCcrW   = {cur_ff.condition_code_reg, cur_ff.condition_code_reg};
        nxt_ff.sp        = cur_ff.sp - 16'h0002;
        nxt_ff.condition_code_reg[MASK_FLAG_BIT] = 1'b1;
        nxt_ff.seq       = FETCH;
      end
      FETCH:
      begin
        nxt_ff.vecRd   = 1'b1;
        nxt_ff.vecAddr = {9'h000, cur_ff.lastVec, 1'b0};
        nxt_ff.seq     = TBL_WAIT;
      end
      // table entry arrives a cycle after the read strobe
      TBL_WAIT: nxt_ff.seq = LOAD;
      LOAD:
      begin
        nxt_ff.pc  = vecData;
        nxt_ff.seq = IDLE;
      end
      default:  nxt_ff.seq = IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_ff       <= '0;
      cur_ff.seq   <= IDLE;
      cur_ff.pc    <= PC_RESET;
      cur_ff.condition_code_reg   <= CCR_RESET;
      cur_ff.sp    <= SP_RESET;
      cur_ff.wait_ <= 1'b1;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign link.regWr     = cur_ff.regWr;
  assign link.regRd     = cur_ff.regRd;
  assign link.regAddr   = cur_ff.devAddr;
  assign link.regWdata  = cur_ff.regWdata;
  assign link.irqAck    = cur_ff.irqAck;
  assign link.ackVector = cur_ff.lastVec;
  assign link.maskFlag  = cur_ff.condition_code_reg[MASK_FLAG_BIT];
  assign avsReaddata    = cur_ff.rdata;
  assign avsWaitrequest = cur_ff.wait_;
  assign stackWe        = cur_ff.stackWe;
  assign stackAddr      = cur_ff.stackAddr;
  assign stackData      = cur_ff.stackData;
  assign vecRd          = cur_ff.vecRd;
  assign vecAddr        = cur_ff.vecAddr;

endmodule
`default_nettype wire

// [design/iak_pkg.sv]
////////////////////////////////////////////////////////////////////////////////
// shared constants for the arbiter and the core end
package iak_pkg;

  // device register map, byte addresses on the core's register port
  localparam logic [15:0] SYS_CTRL_ADDR   = 16'hffc4;  // system_control_reg
  localparam logic [15:0] SENSE_ADDR      = 16'hffc6;  // ext_sense_control
  localparam logic [15:0] ENABLE_ADDR     = 16'hffc7;  // ext_enable_control
  localparam logic [15:0] KEY_MASK_ADDR   = 16'hfff1;  // key_sense_mask

  // reset values
  localparam logic [7:0]  SYS_CTRL_RESET  = 8'h09;     // bit3 reads one, bit2 edge select zero
  localparam logic [7:0]  SENSE_RESET     = 8'hb8;     // all sense bits level
  localparam logic [7:0]  ENABLE_RESET    = 8'hb8;     // all lines disabled
  localparam logic [7:0]  KEY_MASK_RESET  = 8'hff;     // all keys blocked

  // writable bit masks
  localparam logic [7:0]  SYS_CTRL_WMASK  = 8'hf7;     // bit3 read only
  localparam logic [7:0]  GROUP_WMASK     = 8'h47;     // bits 0..2 and 6

  // field positions
  localparam int          NMI_EDGE_BIT    = 2;         // nonmask_edge_select
  localparam int          KEY_GROUP_BIT   = 6;         // key_group_sense_sel / key_group_enable
  localparam int          MASK_FLAG_BIT   = 7;         // global mask flag in condition_code_reg

  // vector numbers
  localparam logic [5:0]  VEC_NMI         = 6'h03;
  localparam logic [5:0]  VEC_LINE0       = 6'h04;
  localparam logic [5:0]  VEC_KEY_GROUP   = 6'h0a;
  localparam logic [5:0]  VEC_INT_BASE    = 6'h11;     // 17, internal sources 0..19
  localparam logic [5:0]  VEC_INT_LAST    = 6'h2c;     // 44, internal source 20
  localparam int          INT_SOURCES     = 21;
  localparam int          KEY_INPUTS      = 8;

  // core end: avalon word indices
  localparam logic [2:0]  AV_CMD          = 3'h0;
  localparam logic [2:0]  AV_PC           = 3'h1;
  localparam logic [2:0]  AV_CCR          = 3'h2;
  localparam logic [2:0]  AV_SP           = 3'h3;
  localparam logic [2:0]  AV_DEV_ADDR     = 3'h4;
  localparam logic [2:0]  AV_DEV_DATA     = 3'h5;
  localparam logic [2:0]  AV_LAST_VEC     = 3'h6;

  // command bits
  localparam int          CMD_INSTR_END   = 0;
  localparam int          CMD_CCR_MOD     = 1;
  localparam int          CMD_RETURN      = 2;

  // core end reset values
  localparam logic [7:0]  CCR_RESET       = 8'h80;     // mask flag set after reset
  localparam logic [15:0] SP_RESET        = 16'hff80;
  localparam logic [15:0] PC_RESET        = 16'h0000;

endpackage

// [design/iak_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// link between the interrupt arbiter and the processor core end
interface iak_link_if;
  logic        regWr;       // register write pulse, core
  logic        regRd;       // register read pulse, core
  logic [15:0] regAddr;     // register address, core
  logic [7:0]  regWdata;    // register write data, core
  logic [7:0]  regRdata;    // register read data, arbiter
  logic        regRdValid;  // read data valid pulse, arbiter
  logic        irqReq;      // request to the core, arbiter
  logic [5:0]  irqVector;   // winning vector number, arbiter
  logic        irqAck;      // request taken pulse, core
  logic [5:0]  ackVector;   // vector that was taken, core
  logic        maskFlag;    // global mask flag, core

  modport dev  (input regWr, regRd, regAddr, regWdata, irqAck, ackVector, maskFlag,
                output regRdata, regRdValid, irqReq, irqVector);
  modport core (output regWr, regRd, regAddr, regWdata, irqAck, ackVector, maskFlag,
                input regRdata, regRdValid, irqReq, irqVector);
endinterface
`default_nettype wire

// [design/iak_arbiter.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module iak_arbiter
  import iak_pkg::*;
(
  input  wire logic                        clk,          // system clock
  input  wire logic                        nrst,         // async reset, active low
  iak_link_if.dev                          link,         // core side
  input  wire logic                        nmiPin,       // nonmaskable pin
  input  wire logic [2:0]                  extLineN,     // ext_request_line0..2, active low
  input  wire logic [iak_pkg::KEY_INPUTS-1:0] keyInN,    // key_sense_input, active low
  input  wire logic [iak_pkg::INT_SOURCES-1:0] intReq,   // internal requests
  input  wire logic [iak_pkg::INT_SOURCES-1:0] intEnable,// module enable bits
  input  wire logic                        hwStandby,    // hardware standby
  input  wire logic                        swStandby,    // software standby
  output logic                             wakeReq       // wake from software standby
);
  import iak_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [11:0] sync1;       // first sync stage {nmi, lines, keys}
    logic [11:0] sync2;       // second sync stage
    logic        prevNmi;     // last nmi level
    logic [3:0]  prevLow;     // last active state of lines and key group
    logic        nmiPend;     // nonmaskable pending
    logic [3:0]  edgePend;    // edge pending per group
    logic [7:0]  sysCtrl;     // system_control_reg
    logic [7:0]  sense;       // ext_sense_control
    logic [7:0]  enable;      // ext_enable_control
    logic [7:0]  keyMask;     // key_sense_mask
    logic [7:0]  rdata;       // read data
    logic        rdValid;     // read data valid
    logic        irqReq;      // request out
    logic [5:0]  irqVec;      // vector out
    logic        wake;        // wake out
  } iak_arb_state_type;

  iak_arb_state_type cur_ff;  // registered state
  iak_arb_state_type nxt_ff;  // next state

  // group bit position in sense and enable registers
  function automatic int grpBit(input int g);
    return (g == 3) ? KEY_GROUP_BIT : g;
  endfunction

  // vector of internal source i
  function automatic logic [5:0] intVec(input int i);
    return (i == INT_SOURCES - 1) ? VEC_INT_LAST : VEC_INT_BASE + 6'(i);
  endfunction

  // vector of external group g
  function automatic logic [5:0] grpVec(input int g);
    return (g == 3) ? VEC_KEY_GROUP : VEC_LINE0 + 6'(g);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic [3:0] lowNow;       // active level per group
    logic       nmiLvl;       // synced nmi level
    logic       nmiEdge;      // selected nmi edge
    logic [3:0] grpReq;       // requests reaching the arbiter
    logic       found;        // winner chosen
    logic [5:0] winVec;       // winning vector
    lowNow  = '0;
    nmiLvl  = 1'b0;
    nmiEdge = 1'b0;
    grpReq  = '0;
    found   = 1'b0;
    winVec  = '0;
    nxt_ff  = cur_ff;

    // two stage sync; pins read whatever their direction
    nxt_ff.sync1 = {nmiPin, extLineN, keyInN};
    nxt_ff.sync2 = cur_ff.sync1;

    // active levels; keys masked then ORed
    lowNow[2:0] = ~cur_ff.sync2[10:8];
    lowNow[3]   = |(~cur_ff.sync2[7:0] & ~cur_ff.keyMask);
    nmiLvl      = cur_ff.sync2[11];
    nmiEdge     = cur_ff.sysCtrl[NMI_EDGE_BIT] ? (nmiLvl & ~cur_ff.prevNmi)
                                               : (~nmiLvl & cur_ff.prevNmi);
    nxt_ff.prevNmi = nmiLvl;
    nxt_ff.prevLow = lowNow;

    // register writes
    nxt_ff.rdValid = 1'b0;
    if (link.regWr)
    begin
      case (link.regAddr)
        SYS_CTRL_ADDR: nxt_ff.sysCtrl = (link.regWdata & SYS_CTRL_WMASK) | (SYS_CTRL_RESET & ~SYS_CTRL_WMASK);
        SENSE_ADDR:    nxt_ff.sense   = (link.regWdata & GROUP_WMASK) | ~GROUP_WMASK;
        ENABLE_ADDR:   nxt_ff.enable  = (link.regWdata & GROUP_WMASK) | ~GROUP_WMASK;
        KEY_MASK_ADDR: nxt_ff.keyMask = link.regWdata;
        default:       ;      // unmapped write ignored
      endcase
    end

    // register reads, answer one cycle later
    if (link.regRd)
    begin
      nxt_ff.rdValid = 1'b1;
      case (link.regAddr)
        SYS_CTRL_ADDR: nxt_ff.rdata = cur_ff.sysCtrl;
        SENSE_ADDR:    nxt_ff.rdata = cur_ff.sense;
        ENABLE_ADDR:   nxt_ff.rdata = cur_ff.enable;
        KEY_MASK_ADDR: nxt_ff.rdata = cur_ff.keyMask;
        default:       nxt_ff.rdata = 8'h00;  // unmapped reads zero
      endcase
    end

    // clears first, sets after so a new edge wins
    if (link.irqAck && link.ackVector == VEC_NMI)
      nxt_ff.nmiPend = 1'b0;
    if (nmiEdge && !hwStandby)
      nxt_ff.nmiPend = 1'b1;
    if (hwStandby)
      nxt_ff.nmiPend = 1'b0;

    for (int g = 0; g < 4; g++)
    begin
      if (link.irqAck && link.ackVector == grpVec(g))
        nxt_ff.edgePend[g] = 1'b0;
      if (link.maskFlag && !cur_ff.sense[grpBit(g)] && !cur_ff.enable[grpBit(g)])
        nxt_ff.edgePend[g] = 1'b0;
      if (cur_ff.sense[grpBit(g)] && cur_ff.enable[grpBit(g)] && lowNow[g] && !cur_ff.prevLow[g])
        nxt_ff.edgePend[g] = 1'b1;
      // level requests need enable; captured edges do not
      grpReq[g] = (cur_ff.enable[grpBit(g)] && !cur_ff.sense[grpBit(g)] && lowNow[g])
                  || cur_ff.edgePend[g];
    end

    // fixed priority: nmi, lines 0..2, key group, internal
    if (cur_ff.nmiPend && !hwStandby)
    begin
      found  = 1'b1;
      winVec = VEC_NMI;
    end
    if (!link.maskFlag)
    begin
      for (int g = 0; g < 4; g++)
        if (!found && grpReq[g])
        begin
          found  = 1'b1;
          winVec = grpVec(g);
        end
      for (int i = 0; i < INT_SOURCES; i++)
        if (!found && intReq[i] && intEnable[i])
        begin
          found  = 1'b1;
          winVec = intVec(i);
        end
    end
    nxt_ff.irqReq = found;
    nxt_ff.irqVec = found ? winVec : cur_ff.irqVec;

    // any external request wakes software standby
    nxt_ff.wake = swStandby && (cur_ff.nmiPend || (|grpReq));
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_ff         <= '0;
      cur_ff.sync1   <= 12'hfff;
      cur_ff.sync2   <= 12'hfff;
      cur_ff.prevNmi <= 1'b1;
      cur_ff.sysCtrl <= SYS_CTRL_RESET;
      cur_ff.sense   <= SENSE_RESET;
      cur_ff.enable  <= ENABLE_RESET;
      cur_ff.keyMask <= KEY_MASK_RESET;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign link.regRdata   = cur_ff.rdata;
  assign link.regRdValid = cur_ff.rdValid;
  assign link.irqReq     = cur_ff.irqReq;
  assign link.irqVector  = cur_ff.irqVec;
  assign wakeReq         = cur_ff.wake;

endmodule
`default_nettype wire

// [tb/iak_properties.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// watches the link between the arbiter and the core end
module iak_properties
  import iak_pkg::*;
(
  input wire logic       clk,         // system clock
  input wire logic       nrst,        // async reset, active low
  input wire logic       regWr,       // register write pulse
  input wire logic       regRd,       // register read pulse
  input wire logic       regRdValid,  // read data valid pulse
  input wire logic       irqReq,      // request to the core
  input wire logic [5:0] irqVector,   // winning vector
  input wire logic       irqAck,      // request taken pulse
  input wire logic [5:0] ackVector,   // vector taken
  input wire logic       maskFlag     // global mask flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (regRd |=> regRdValid ##1 !regRdValid) else $error("read not answered once");
  a_valid_cause: assert property (regRdValid |-> $past(regRd)) else $error("read valid without read");
  a_bus_apart: assert property (!(regWr && regRd)) else $error("write and read together");
  a_vector_known: assert property (irqReq |-> irqVector inside {6'h03, [6'h04:6'h06], 6'h0a, [6'h11:6'h24], 6'h2c})
    else $error("illegal vector");
  a_mask_only_nmi: assert property (maskFlag [*3] ##0 irqReq |-> irqVector == VEC_NMI)
    else $error("maskable request under mask");
  a_ack_matches: assert property (irqAck |-> $past(irqReq) && ackVector == $past(irqVector))
    else $error("ack without matching request");
  a_ack_single: assert property (irqAck |=> !irqAck) else $error("ack longer than a pulse");
  a_take_masks: assert property (irqAck |-> ##[2:4] maskFlag) else $error("mask flag not set");
endmodule
`default_nettype wire

// [tb/iak_interrupt_arbiter_with_key_sense_tb.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// both ends joined; bench drives pins and the avalon port
module iak_interrupt_arbiter_with_key_sense_tb;
  import iak_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, nmiPin = 1'b1, avsRead = 1'b0, avsWrite = 1'b0;
  logic        hwStby = 1'b0, swStby = 1'b0;
  logic        avsWaitrequest, stackWe, vecRd, wakeReq, e;
  logic [2:0]  extLineN = 3'h7, avsAddress = 3'h0;
  logic [7:0]  keyInN = 8'hff, m, k;
  logic [20:0] intReq = '0, intEn = '0;
  logic [31:0] avsWritedata = '0, avsReaddata, q, rng = 32'h063b7686;
  logic [15:0] stackAddr, stackData, vecAddr, vecData = '0;
  logic [5:0]  lastV = '0;
  logic [5:0]  vt [4] = '{6'h04, 6'h05, 6'h06, 6'h0a};
  int          failCount = 0, checksDone = 0, cyc = 0, j = 0;
  iak_link_if lnk ();
  iak_arbiter i_iak_arbiter (.clk, .nrst, .link(lnk), .nmiPin, .extLineN, .keyInN, .intReq,
    .intEnable(intEn), .hwStandby(hwStby), .swStandby(swStby), .wakeReq);
  iak_core_end i_iak_core_end (.clk, .nrst, .link(lnk), .avsAddress, .avsRead, .avsWrite, .avsWritedata,
    .avsReaddata, .avsWaitrequest, .stackWe, .stackAddr, .stackData, .vecRd, .vecAddr, .vecData);
  iak_properties i_iak_properties (.clk, .nrst, .regWr(lnk.regWr), .regRd(lnk.regRd),
    .regRdValid(lnk.regRdValid), .irqReq(lnk.irqReq), .irqVector(lnk.irqVector), .irqAck(lnk.irqAck),
    .ackVector(lnk.ackVector), .maskFlag(lnk.maskFlag));
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // vector table, internal noise with enabled sources held, stack watch, timeout
  always @(posedge clk)
  begin
    vecData <= ~vecAddr;
    intReq <= (rng[20:0] ^ cyc[20:0]) | intEn;
    cyc <= cyc + 1;
    if (stackWe === 1'b1 && stackAddr[1] === 1'b0)
      chk(stackData[15:8], stackData[7:0]);
    if (cyc == 40000)
    begin
      failCount++;
      finishTest;
    end
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      failCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task av(input logic w, input logic [2:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWritedata <= d;
    do @(posedge clk); while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    // one idle edge so a following call never re-raises in the same step
    @(posedge clk);
  endtask
  task dw(input logic [15:0] a, input logic [7:0] d);
    av(1'b1, AV_DEV_ADDR, {16'h0, a});
    av(1'b1, AV_DEV_DATA, {24'h0, d});
  endtask
  task dr(input logic [15:0] a, input logic [7:0] x);
    av(1'b1, AV_DEV_ADDR, {16'h0, a});
    av(1'b0, AV_DEV_DATA, 32'h0);
    chk(q[7:0], x);
  endtask
  // set mask, give a command, then judge whether a take happened
  task tk(input logic [7:0] c, input logic [2:0] cmd, input logic tf, input logic [5:0] ev);
    av(1'b1, AV_CCR, {24'h0, c});
    repeat (8) @(posedge clk);
    av(1'b1, AV_CMD, {29'h0, cmd});
    repeat (10) @(posedge clk);
    av(1'b0, AV_CMD, 32'h0);
    chk(q[0], tf | c[7]);
    if (tf)
      lastV = ev;
    av(1'b0, AV_LAST_VEC, 32'h0);
    chk(q[5:0], lastV);
    if (tf)
    begin
      av(1'b0, AV_PC, 32'h0);
      chk(q[15:0], 16'(~{9'h0, ev, 1'b0}));
    end
  endtask
  task finishTest;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    dr(SYS_CTRL_ADDR, 8'h09);
    dr(SENSE_ADDR, 8'hb8);
    dr(ENABLE_ADDR, 8'hb8);
    dr(KEY_MASK_ADDR, 8'hff);
    dr(16'hffc5, 8'h00);
    dw(SENSE_ADDR, 8'hff);
    dr(SENSE_ADDR, 8'hff);
    dw(SYS_CTRL_ADDR, 8'h00);
    dr(SYS_CTRL_ADDR, 8'h08);
    dw(SENSE_ADDR, 8'h00);
    extLineN <= 3'h0;
    keyInN <= 8'hfe;
    tk(8'h00, 3'h1, 1'b0, 6'h0);
    dw(ENABLE_ADDR, 8'h47);
    dw(KEY_MASK_ADDR, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      tk(8'h00, 3'h1, 1'b1, vt[i]);
      if (i < 3)
        extLineN[i] <= 1'b1;
    end
    keyInN <= 8'hff;
    extLineN <= 3'h5;
    tk(8'h80, 3'h1, 1'b0, 6'h0);
    // pending line request wakes software standby only while in it
    swStby <= 1'b1;
    repeat (3) @(posedge clk);
    chk(wakeReq, 1'b1);
    swStby <= 1'b0;
    repeat (3) @(posedge clk);
    chk(wakeReq, 1'b0);
    nmiPin <= 1'b0;
    tk(8'h80, 3'h1, 1'b1, VEC_NMI);
    dw(SYS_CTRL_ADDR, 8'h04);
    nmiPin <= 1'b1;
    tk(8'h80, 3'h1, 1'b1, VEC_NMI);
    // rising nmi edge inside hardware standby must be dropped
    extLineN <= 3'h7;
    hwStby <= 1'b1;
    nmiPin <= 1'b0;
    repeat (6) @(posedge clk);
    nmiPin <= 1'b1;
    repeat (6) @(posedge clk);
    hwStby <= 1'b0;
    tk(8'h00, 3'h1, 1'b0, 6'h0);
    extLineN <= 3'h5;
    tk(8'h00, 3'h3, 1'b0, 6'h0);
    dw(SENSE_ADDR, 8'h01);
    extLineN <= 3'h6;
    repeat (6) @(posedge clk);
    extLineN <= 3'h7;
    tk(8'h00, 3'h1, 1'b1, VEC_LINE0);
    tk(8'h00, 3'h1, 1'b0, 6'h0);
    for (int i = 0; i < 3; i++)
    begin
      // pass 1 pulses while disabled; pass 2 captures, then clears under mask
      if (i != 1)
        dw(ENABLE_ADDR, 8'h47);
      extLineN <= 3'h6;
      repeat (6) @(posedge clk);
      extLineN <= 3'h7;
      dw(ENABLE_ADDR, 8'h46);
      if (i == 2)
      begin
        av(1'b1, AV_CCR, 32'h80);
        dw(SENSE_ADDR, 8'h00);
        dw(SENSE_ADDR, 8'h01);
      end
      tk(8'h00, 3'h1, i == 0, VEC_LINE0);
    end
    dw(SENSE_ADDR, 8'h00);
    dw(KEY_MASK_ADDR, 8'hff);
    keyInN <= 8'hf7;
    tk(8'h00, 3'h1, 1'b0, 6'h0);
    for (int i = 0; i < 8; i++)
    begin
      m = 8'(xs());
      k = (i == 0) ? 8'hf7 : 8'(xs());
      e = |(~k & ~m);
      dw(KEY_MASK_ADDR, m);
      keyInN <= k;
      tk(8'h00, 3'h1, e, VEC_KEY_GROUP);
    end
    keyInN <= 8'hff;
    extLineN <= 3'h3;
    av(1'b1, AV_PC, 32'h1234);
    tk(8'h00, 3'h1, 1'b1, 6'h06);
    extLineN <= 3'h7;
    av(1'b1, AV_CMD, 32'h4);
    av(1'b0, AV_PC, 32'h0);
    chk(q[15:0], 16'h1234);
    av(1'b0, AV_CCR, 32'h0);
    chk(q[7:0], 8'h00);
    // internal sources: the last one alone, then a random lower one beside it
    intEn <= 21'h100000;
    tk(8'h00, 3'h1, 1'b1, VEC_INT_LAST);
    for (int i = 0; i < 3; i++)
    begin
      j = int'(xs() % 32'd20);
      intEn <= 21'h100000 | (21'h1 << j);
      tk(8'h00, 3'h1, 1'b1, VEC_INT_BASE + 6'(j));
    end
    intEn <= '0;
    finishTest;
  end
endmodule
`default_nettype wire
